// file: bench/cpsr_core_asserts.sv
`timescale 1ns/1ns
`default_nettype none
// port-level checks on the program state block
module cpsr_core_asserts (
    input wire logic mclk_i,
    input wire logic rst_i,
    input wire logic push_i,
    input wire logic pop_i,
    input wire logic irq_ack_i,
    input wire logic load_flag_word_op_i,
    input wire logic [7:0] flag_imm_i,
    input wire logic load_stack_pointer_op_i,
    input wire logic [7:0] reg_b_i,
    input wire logic irq_lvl1_req_i,
    input wire logic irq_lvl2_req_i,
    input wire logic mem_we_o,
    input wire logic mem_re_o,
    input wire logic [15:0] mem_addr_o,
    input wire logic [7:0] mem_wdata_o,
    input wire logic [7:0] stack_pointer_o,
    input wire logic [7:0] flag_word_o,
    input wire logic pop_valid_o,
    input wire logic irq_lvl1_o,
    input wire logic irq_lvl2_o,
    input wire logic busy_o
);
    default clocking @(posedge mclk_i); endclocking
    default disable iff (rst_i);
    // requests count only in run state, never in a pop completion
    wire run_ok = !busy_o && !mem_re_o;
    a_reset_walk: assert property ($fell(rst_i) |-> busy_o
        ##1 mem_we_o && mem_addr_o == 16'h0000 ##1 mem_we_o && mem_addr_o == 16'h0001
        ##1 mem_re_o && mem_addr_o == 16'h7ffe ##1 mem_re_o && mem_addr_o == 16'h7fff
        ##1 !busy_o) else $error("reset walk wrong");
    a_reset_state: assert property ($fell(rst_i) |-> stack_pointer_o == 8'h01
        && flag_word_o == 8'h00) else $error("reset state wrong");
    a_push_order: assert property (push_i && !pop_i && !irq_ack_i && run_ok |=>
        stack_pointer_o == $past(stack_pointer_o) + 8'h01 && mem_we_o
        && mem_addr_o == {8'h00, stack_pointer_o}) else $error("push order wrong");
    a_pop_order: assert property (pop_i && !irq_ack_i && run_ok |=> mem_re_o
        && mem_addr_o == {8'h00, $past(stack_pointer_o)} ##1 pop_valid_o
        && stack_pointer_o == $past(stack_pointer_o, 2) - 8'h01) else $error("pop order wrong");
    a_ack_save: assert property (irq_ack_i && run_ok |=> mem_we_o
        && mem_wdata_o == $past(flag_word_o) && flag_word_o == 8'h00) else $error("ack wrong");
    a_flag_load: assert property (load_flag_word_op_i && !irq_ack_i && run_ok |=>
        flag_word_o == $past(flag_imm_i)) else $error("flag load wrong");
    a_ptr_load: assert property (load_stack_pointer_op_i && !push_i && !pop_i
        && !irq_ack_i && run_ok |=> stack_pointer_o == $past(reg_b_i))
        else $error("pointer load wrong");
    a_irq_gate: assert property (irq_lvl1_o == $past(irq_lvl1_req_i && flag_word_o[2])
        && irq_lvl2_o == $past(irq_lvl2_req_i && flag_word_o[3])) else $error("irq gate wrong");
endmodule // cpsr_core_asserts
bind cpsr_core cpsr_core_asserts u_chk (.*);
`default_nettype wire

// file: bench/cpsr_mem_model.sv
`timescale 1ns/1ns
`default_nettype none
// register file memory plus the two reset vector bytes
module cpsr_mem_model #(
    parameter logic [7:0] VEC_HI = 8'h5a, // upper vector byte
    parameter logic [7:0] VEC_LO = 8'hc3 // lower vector byte
) (
    input wire logic mclk_i,
    input wire logic we_i,
    input wire logic re_i,
    input wire logic [15:0] addr_i,
    input wire logic [7:0] wdata_i,
    output logic [7:0] rdata_o
);
    logic [7:0] rf [0:255]; // register file bytes
    logic [7:0] idle_pat = 8'h96; // keeps moving so stale data never looks valid
    initial for (int i = 0; i < 256; i++) rf[i] = 8'hee;
    // writes land at the edge after the strobe
    always @(posedge mclk_i) begin
        idle_pat <= idle_pat + 8'h3b;
        if (we_i && addr_i[15:8] == 8'h00) begin
            rf[addr_i[7:0]] <= wdata_i;
        end
    end
    // read data only while the read strobe stands
    always @* begin
        rdata_o = idle_pat;
        if (re_i && addr_i == 16'h7ffe) rdata_o = VEC_HI;
        else if (re_i && addr_i == 16'h7fff) rdata_o = VEC_LO;
        else if (re_i && addr_i[15:8] == 8'h00) rdata_o = rf[addr_i[7:0]];
    end
endmodule // cpsr_mem_model
`default_nettype wire

// file: bench/tb_cpu_program_state_registers.sv
`timescale 1ns/1ns
`default_nettype none
`include "cpsr_defs.vh"
module tb_cpu_program_state_registers;
    localparam int OP_PUSH = 0, OP_POP = 1, OP_SPLD = 2, OP_SPST = 3, OP_FUPD = 4, OP_CUPD = 5;
    localparam int OP_FLD = 6, OP_CSET = 7, OP_CCLR = 8, OP_ACK = 9, OP_IRET = 10;
    localparam int OP_FPLD = 11, OP_FPINC = 12;
    logic mclk_i = 1'b0, rst_i = 1'b1, alu_carry_i = 1'b0, src_msb_i = 1'b0, dst_msb_i = 1'b0;
    logic irq_lvl1_req_i = 1'b0, irq_lvl2_req_i = 1'b0;
    logic [12:0] stb = 13'h0000; // one strobe per request kind
    logic [7:0] push_data_i = 8'h00, reg_b_i = 8'h00, alu_result_i = 8'h00, divisor_i = 8'h00;
    logic [7:0] accum_i = 8'h00, flag_imm_i = 8'h00;
    logic [1:0] vclass_i = 2'd0;
    logic [15:0] fp_value_i = 16'h0000;
    wire push_i = stb[0], pop_i = stb[1], load_stack_pointer_op_i = stb[2];
    wire store_stack_pointer_op_i = stb[3], flag_update_i = stb[4], carry_update_i = stb[5];
    wire load_flag_word_op_i = stb[6], set_carry_op_i = stb[7], clear_carry_op_i = stb[8];
    wire irq_ack_i = stb[9], interrupt_return_op_i = stb[10], fp_load_i = stb[11];
    wire fp_inc_i = stb[12];
    wire [7:0] mem_rdata_i, mem_wdata_o, stack_pointer_o, flag_word_o, pop_data_o, store_b_data_o;
    wire [15:0] mem_addr_o, next_fetch_pointer_o;
    wire mem_we_o, mem_re_o, pop_valid_o, store_b_we_o, irq_lvl1_o, irq_lvl2_o, busy_o;
    int err_total = 0, n_checks = 0;
    cpsr_core dut (.*);
    cpsr_mem_model u_mem (.mclk_i(mclk_i), .we_i(mem_we_o), .re_i(mem_re_o),
        .addr_i(mem_addr_o), .wdata_i(mem_wdata_o), .rdata_o(mem_rdata_i));
    initial forever #50 mclk_i = ~mclk_i;
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        n_checks++;
        if (seen !== exp) begin
            err_total++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic step(input int n);
        repeat (n) @(posedge mclk_i);
    endtask
    // one-cycle request, then sample at the falling edge after the answer
    task automatic go(input int k);
        step(1);
        stb <= 13'h0001 << k;
        step(1);
        stb <= 13'h0000;
        @(negedge mclk_i);
    endtask
    task automatic alu(input logic [7:0] res, input logic [2:0] csd, input logic [1:0] vc);
        alu_result_i <= res;
        {alu_carry_i, src_msb_i, dst_msb_i} <= csd;
        vclass_i <= vc;
        go(OP_FUPD);
    endtask
    task automatic t_reset;
        step(5);
        rst_i <= 1'b0;
        step(6);
        @(negedge mclk_i);
        chk(next_fetch_pointer_o, 16'h5ac3);
        chk({stack_pointer_o, flag_word_o}, 16'h0100);
        chk({u_mem.rf[0], u_mem.rf[1]}, 16'h0000);
        chk(u_mem.rf[2], 16'h00ee);
    endtask
    task automatic t_stack;
        reg_b_i <= 8'hfe;
        go(OP_SPLD);
        chk({stack_pointer_o, flag_word_o}, 16'hfe00);
        push_data_i <= 8'h3c;
        go(OP_PUSH);
        chk({mem_we_o, 7'h00, mem_wdata_o}, 16'h803c);
        chk(stack_pointer_o, 16'h00ff);
        push_data_i <= 8'hd2;
        go(OP_PUSH);
        chk(stack_pointer_o, 16'h0000);
        go(OP_POP);
        step(1);
        @(negedge mclk_i);
        chk({pop_valid_o, pop_data_o}, 16'h01d2);
        chk({u_mem.rf[8'hff], stack_pointer_o}, 16'h3cff);
        go(OP_SPST);
        chk({store_b_we_o, store_b_data_o}, 16'h01ff);
    endtask
    task automatic t_flags;
        irq_lvl1_req_i <= 1'b1;
        irq_lvl2_req_i <= 1'b1;
        flag_imm_i <= 8'h0c;
        go(OP_FLD);
        chk(flag_word_o, 16'h000c);
        step(1);
        @(negedge mclk_i);
        chk({irq_lvl1_o, irq_lvl2_o}, 16'h0003);
        flag_imm_i <= 8'h04;
        go(OP_FLD);
        step(1);
        @(negedge mclk_i);
        chk({irq_lvl1_o, irq_lvl2_o}, 16'h0002);
        alu(8'h80, 3'b000, `CPSR_V_ADD);
        chk(flag_word_o, 16'h0054);
        alu(8'h80, 3'b000, `CPSR_V_SUB);
        chk(flag_word_o[7:4], 16'h0004);
        alu(8'h00, 3'b110, `CPSR_V_SUB);
        chk(flag_word_o[7:4], 16'h000b);
        divisor_i <= 8'h10;
        accum_i <= 8'h10;
        alu(8'h01, 3'b000, `CPSR_V_DIV);
        chk(flag_word_o[4], 16'h0001);
        divisor_i <= 8'h11;
        alu(8'h01, 3'b000, `CPSR_V_DIV);
        chk(flag_word_o[4], 16'h0000);
        go(OP_CSET);
        chk(flag_word_o[7], 16'h0001);
        go(OP_CCLR);
        chk(flag_word_o[7], 16'h0000);
        alu_carry_i <= 1'b1;
        go(OP_CUPD);
        chk(flag_word_o[7], 16'h0001);
    endtask
    task automatic t_irq_fp;
        flag_imm_i <= 8'hfc;
        go(OP_FLD);
        go(OP_ACK);
        chk({flag_word_o, stack_pointer_o}, 16'h0000);
        step(1);
        @(negedge mclk_i);
        chk(u_mem.rf[0], 16'h00fc);
        go(OP_IRET);
        step(1);
        @(negedge mclk_i);
        chk({flag_word_o, stack_pointer_o}, 16'hfcff);
        fp_value_i <= 16'h12ff;
        go(OP_FPLD);
        go(OP_FPINC);
        chk(next_fetch_pointer_o, 16'h1300);
        chk(flag_word_o, 16'h00fc);
    endtask
    task automatic finish_test;
        if (err_total == 0 && n_checks > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    // cut a hang short well after the sequence should be done
    initial begin
        #100000;
        err_total++;
        finish_test;
    end
    initial begin
        t_reset;
        t_stack;
        t_flags;
        t_irq_fp;
        finish_test;
    end
endmodule // tb_cpu_program_state_registers
`default_nettype wire

// file: hdl/cpsr_core.v
`timescale 1ns/1ns
`default_nettype none
`include "cpsr_defs.vh"
module cpsr_core #(
    // nonzero for parts with only 128 bytes of ram
    parameter SMALL_RAM = 0
) (
    input wire mclk_i,
    input wire rst_i,
    // stack operations from the sequencer
    input wire push_i,
    input wire pop_i,
    input wire [7:0] push_data_i,
    // pointer transfer with register b
    input wire load_stack_pointer_op_i,
    input wire store_stack_pointer_op_i,
    input wire [7:0] reg_b_i,
    // flag updates
    input wire flag_update_i,
    input wire carry_update_i,
    input wire [7:0] alu_result_i,
    input wire alu_carry_i,
    input wire src_msb_i,
    input wire dst_msb_i,
    input wire [1:0] vclass_i,
    input wire [7:0] divisor_i,
    input wire [7:0] accum_i,
    input wire load_flag_word_op_i,
    input wire [7:0] flag_imm_i,
    input wire set_carry_op_i,
    input wire clear_carry_op_i,
    input wire irq_ack_i,
    input wire interrupt_return_op_i,
    // raw interrupt requests per level
    input wire irq_lvl1_req_i,
    input wire irq_lvl2_req_i,
    // fetch pointer control
    input wire fp_load_i,
    input wire [15:0] fp_value_i,
    input wire fp_inc_i,
    // register file read data
    input wire [7:0] mem_rdata_i,
    // register file port
    output reg mem_we_o,
    output reg mem_re_o,
    output reg [15:0] mem_addr_o,
    output reg [7:0] mem_wdata_o,
    // visible state
    output reg [7:0] stack_pointer_o,
    output reg [7:0] flag_word_o,
    output reg [15:0] next_fetch_pointer_o,
    output reg [7:0] pop_data_o,
    output reg pop_valid_o,
    output reg store_b_we_o,
    output reg [7:0] store_b_data_o,
    output reg irq_lvl1_o,
    output reg irq_lvl2_o,
    output reg busy_o
);
    // one-hot states
    localparam ST_CLR_A = 7'b0000001;
    localparam ST_CLR_B = 7'b0000010;
    localparam ST_VEC_HI = 7'b0000100;
    localparam ST_VEC_LO = 7'b0001000;
    localparam ST_RUN = 7'b0010000;
    localparam ST_POP = 7'b0100000;
    localparam ST_RTI = 7'b1000000;

    reg [6:0] state_r;
    // pointer is eight bits
    // aliases for the register outputs
    wire [7:0] sp = stack_pointer_o;
    wire [7:0] fw = flag_word_o;
    // incremented pointer, wraps naturally at 8 bits
    wire [7:0] sp_inc = sp + 8'h01;
    wire [3:0] calc_flags;

    // small ram: a push target above 7f has no storage
    function stack_ok;
        input [7:0] addr;
        begin
            stack_ok = (SMALL_RAM == 0) || (addr <= `CPSR_SMALL_TOP);
        end
    endfunction

    cpsr_flag_calc u_calc (
        .result_i(alu_result_i),
        .carry_i(alu_carry_i),
        .src_msb_i(src_msb_i),
        .dst_msb_i(dst_msb_i),
        .vclass_i(vclass_i),
        .divisor_i(divisor_i),
        .accum_i(accum_i),
        .flags_o(calc_flags)
    );

    // main sequencer: reset walk, stack, flags, fetch pointer
    always @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            state_r <= ST_CLR_A;
            stack_pointer_o <= `CPSR_SP_RESET;
            flag_word_o <= `CPSR_FLAG_RESET;
            next_fetch_pointer_o <= 16'h0000;
            mem_we_o <= 1'b0;
            mem_re_o <= 1'b0;
            mem_addr_o <= 16'h0000;
            mem_wdata_o <= 8'h00;
            pop_data_o <= 8'h00;
            pop_valid_o <= 1'b0;
            store_b_we_o <= 1'b0;
            store_b_data_o <= 8'h00;
            busy_o <= 1'b1;
        end else begin
            // strobes default low
            mem_we_o <= 1'b0;
            mem_re_o <= 1'b0;
            pop_valid_o <= 1'b0;
            store_b_we_o <= 1'b0;
            case (state_r)
                ST_CLR_A: begin
                    mem_we_o <= 1'b1;
                    mem_addr_o <= {8'h00, `CPSR_REG_A};
                    mem_wdata_o <= 8'h00;
                    state_r <= ST_CLR_B;
                end
                ST_CLR_B: begin
                    mem_we_o <= 1'b1;
                    mem_addr_o <= {8'h00, `CPSR_REG_B};
                    mem_wdata_o <= 8'h00;
                    state_r <= ST_VEC_HI;
                end
                ST_VEC_HI: begin
                    mem_re_o <= 1'b1;
                    mem_addr_o <= `CPSR_VEC_HI;
                    state_r <= ST_VEC_LO;
                end
                ST_VEC_LO: begin
                    // read data for the upper byte returns this cycle
                    mem_re_o <= 1'b1;
                    mem_addr_o <= `CPSR_VEC_LO;
                    next_fetch_pointer_o[15:8] <= mem_rdata_i;
                    state_r <= ST_POP;
                    busy_o <= 1'b1;
                end
                ST_POP, ST_RTI: begin
                    // pop read data is back: a reset-walk lower byte, a pop or an interrupt return
                    if (busy_o) begin
                        next_fetch_pointer_o[7:0] <= mem_rdata_i;
                        busy_o <= 1'b0;
                    end else if (state_r == ST_RTI) begin
                        flag_word_o <= mem_rdata_i;
                    end else begin
                        pop_data_o <= mem_rdata_i;
                        pop_valid_o <= 1'b1;
                    end
                    if (!busy_o) begin
                        stack_pointer_o <= sp - 8'h01;
                    end
                    state_r <= ST_RUN;
                end
                default: begin
                    // fetch pointer advance or load
                    if (fp_load_i) begin
                        next_fetch_pointer_o <= fp_value_i;
                    end else if (fp_inc_i) begin
                        next_fetch_pointer_o <= next_fetch_pointer_o + 16'h0001;
                    end
                    if (irq_ack_i) begin
                        stack_pointer_o <= sp_inc;
                        mem_we_o <= stack_ok(sp_inc);
                        mem_addr_o <= {8'h00, sp_inc};
                        mem_wdata_o <= fw;
                        flag_word_o <= 8'h00;
                    end else if (interrupt_return_op_i || pop_i) begin
                        mem_re_o <= 1'b1;
                        mem_addr_o <= {8'h00, sp};
                        state_r <= interrupt_return_op_i ? ST_RTI : ST_POP;
                    end else if (push_i) begin
                        stack_pointer_o <= sp_inc;
                        mem_we_o <= stack_ok(sp_inc);
                        mem_addr_o <= {8'h00, sp_inc};
                        mem_wdata_o <= push_data_i;
                    end else if (load_stack_pointer_op_i) begin
                        stack_pointer_o <= reg_b_i;
                    end else if (store_stack_pointer_op_i) begin
                        store_b_we_o <= 1'b1;
                        store_b_data_o <= sp;
                    end
                    if (!irq_ack_i) begin
                        if (load_flag_word_op_i) begin
                            flag_word_o <= flag_imm_i;
                        end else if (flag_update_i) begin
                            // flags land in bits 7 to 4
                            flag_word_o[7:4] <= calc_flags;
                        end else if (carry_update_i) begin
                            flag_word_o[`CPSR_BIT_CARRY] <= alu_carry_i;
                        end else if (set_carry_op_i) begin
                            flag_word_o[`CPSR_BIT_CARRY] <= 1'b1;
                        end else if (clear_carry_op_i) begin
                            flag_word_o[`CPSR_BIT_CARRY] <= 1'b0;
                        end
                    end
                end
            endcase
        end
    end

    // gate irq levels by enables, registered
    always @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            irq_lvl1_o <= 1'b0;
            irq_lvl2_o <= 1'b0;
        end else begin
            irq_lvl1_o <= irq_lvl1_req_i & fw[`CPSR_BIT_IE1];
            irq_lvl2_o <= irq_lvl2_req_i & fw[`CPSR_BIT_IE2];
        end
    end
endmodule // cpsr_core
`default_nettype wire

// file: hdl/cpsr_defs.vh
`ifndef CPSR_DEFS_VH
`define CPSR_DEFS_VH
// stack pointer reset value
`define CPSR_SP_RESET 8'h01
// flag word reset value
`define CPSR_FLAG_RESET 8'h00
// flag word bit positions
`define CPSR_BIT_CARRY 7
`define CPSR_BIT_NEG 6
`define CPSR_BIT_ZERO 5
`define CPSR_BIT_OVF 4
`define CPSR_BIT_IE2 3
`define CPSR_BIT_IE1 2
// reset vector addresses
`define CPSR_VEC_HI 16'h7ffe
`define CPSR_VEC_LO 16'h7fff
// register file addresses of registers a and b
`define CPSR_REG_A 8'h00
`define CPSR_REG_B 8'h01
// highest stack address on small-ram parts
`define CPSR_SMALL_TOP 8'h7f
// flag update classes
`define CPSR_V_NONE 2'd0
`define CPSR_V_ADD 2'd1
`define CPSR_V_SUB 2'd2
`define CPSR_V_DIV 2'd3
`endif

// file: hdl/cpsr_flag_calc.v
`timescale 1ns/1ns
`default_nettype none
`include "cpsr_defs.vh"
// combinational condition flag calculator for alu results
module cpsr_flag_calc (
    input wire [7:0] result_i,
    input wire carry_i,
    input wire src_msb_i,
    input wire dst_msb_i,
    input wire [1:0] vclass_i,
    input wire [7:0] divisor_i,
    input wire [7:0] accum_i,
    output reg [3:0] flags_o
);
    // scratch terms
    reg neg;
    reg ovf;
    always @* begin
        neg = result_i[7];
        ovf = 1'b0;
        case (vclass_i)
            `CPSR_V_ADD: begin
                ovf = (carry_i ^ neg) & ~(src_msb_i ^ dst_msb_i);
            end
            `CPSR_V_SUB: begin
                ovf = (carry_i ^ neg) & (src_msb_i ^ dst_msb_i);
            end
            `CPSR_V_DIV: begin
                ovf = (divisor_i <= accum_i);
            end
            default: begin
                ovf = 1'b0;
            end
        endcase
        flags_o = {carry_i, neg, (result_i == 8'h00), ovf};
    end
endmodule // cpsr_flag_calc
`default_nettype wire
